// ==== core/filter_ctrl_pkg.sv ====
/*
  Constants shared by the filter control register bank: subaddresses,
  field positions, reset values and serial-interface constants.
  Assumes a single 25 MHz clock domain and that SCL and SDA arrive
  already synchronous to that clock.
*/
package filter_ctrl_pkg;
  // Register subaddresses carried in the second byte
  localparam logic [7:0] SUB_CUTOFF = 8'h01;
  localparam logic [7:0] SUB_INTYPE = 8'h02;
  localparam logic [7:0] SUB_OPCTRL = 8'h03;
  // Slave address base; the low address bits come from the strap code
  localparam logic [6:0] SLAVE_BASE = 7'h48;
  localparam logic [6:0] SLAVE_ADS_HI = 7'h49;
  localparam logic [6:0] SLAVE_ADS_OPEN = 7'h4a;
  // Strap codes for the three-state address pin
  localparam logic [1:0] ADS_LOW = 2'h0;
  localparam logic [1:0] ADS_HIGH = 2'h1;
  localparam logic [1:0] ADS_OPEN = 2'h2;
  // Reset values
  localparam logic [7:0] CUTOFF_RST = 8'h00;
  localparam logic [5:0] INTYPE_RST = 6'h00;
  localparam logic [3:0] OPCTRL_RST = 4'h0;
  // Cutoff field layout
  localparam int RANGE_BIT = 7;
  localparam int TUNE_MSB = 6;
  // Input-type register: data bits holding the three channel fields
  localparam int INTYPE_MSB = 7;
  localparam int INTYPE_LSB = 2;
  // Operating register bit positions within the data byte
  localparam int PD_BIT = 7;
  localparam int PAIR_BIT = 6;
  localparam int HALF_BIT = 5;
  localparam int SKIP_BIT = 4;
  // Byte length and bit counter limits
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
endpackage

// ==== core/serial_edge.sv ====
/*
  Edge and bus-condition detector for the two-wire serial port.
  Assumes scl and sda inputs are already synchronous to clk and
  glitch free; a one-cycle registered history is kept here.
*/
module serial_edge (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Line levels
  input wire logic scl,
  input wire logic sda,
  // Detected events, one-cycle pulses
  output logic scl_rise,
  output logic scl_fall,
  output logic start_det,
  output logic stop_det
);
  logic scl_q; // Previous clock line level
  logic sda_q; // Previous data line level

  // Keep one sample of history; idle bus is high
  always_ff @(posedge clk) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce) begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // Start is data falling while clock high, stop is data rising
  assign scl_rise = ce & scl & ~scl_q;
  assign scl_fall = ce & ~scl & scl_q;
  assign start_det = ce & scl & scl_q & sda_q & ~sda;
  assign stop_det = ce & scl & scl_q & ~sda_q & sda;
endmodule

// ==== core/filter_control_register_bank.sv ====
/*
  Write-only control register bank of a three-channel video filter
  buffer, written over a two-wire serial port as slave address,
  subaddress and data byte. Outputs steer the analog filter, the
  input multiplexer and the input stages.
  Assumes scl, sda and the select pin are synchronous to clk, and
  that the open-drain data pin is resolved outside this module.
*/
//
// Contract
// - Data byte stored into subaddressed register
// - Cutoff: range flag bit7, tuning bits6-0
// - Eight-bit code gives 256 two-range settings
// - Three 2-bit channel fields, data bits 7..2
// - Each field selects one input stage
// - Operating bits: down, pair, half, skip
// - Power-down flag high powers analog off
// - Pair flag picks A or B, pin low
// - Select pin high forces input B
// - Half flag halves channels two, three
// - Skip flag bypasses filter, cutoff ignored
// - Skip low passes through the filter
// - No read-back; host only writes
// - Reset loads every default before writes
// - Nack bad address or subaddress; ack data
module filter_control_register_bank (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Address strap, 0 low, 1 high, 2 open
  input wire logic [1:0] ads_code,
  // Two-wire serial port, data pin split open-drain style
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // External pair select pin
  input wire logic pair_select_pin,
  // Analog controls
  output logic [7:0] cutoff_code_value,
  output logic tuning_range_select,
  output logic [6:0] tuning_value,
  output logic [1:0] ch1_input_kind,
  output logic [1:0] ch2_input_kind,
  output logic [1:0] ch3_input_kind,
  output logic power_down_flag,
  output logic use_input_b,
  output logic ch1_half_cutoff,
  output logic ch23_half_cutoff,
  output logic filter_bypass,
  output logic filter_enable
);
  // Serial transfer phases
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, // Waiting for start
    ST_ADDR = 3'b001, // Shifting slave address
    ST_SUB = 3'b010,  // Shifting subaddress
    ST_DATA = 3'b011, // Shifting control data
    ST_DONE = 3'b100, // Ignoring until stop or repeated start
    ST_NOREG = 3'b101 // Subaddress refused; data byte acked, dropped
  } phase_t;

  phase_t phase_q;
  logic [3:0] bit_q;      // Bit index within byte, 8 is the ack slot
  logic [7:0] shift_q;    // Incoming byte
  logic [7:0] sub_q;      // Latched subaddress
  logic ack_q;            // Driving the ack low
  logic ack_due_q;        // Ack owed for the byte just shifted in
  logic [1:0] ads_q;      // Strap captured after reset release
  logic ads_taken_q;
  logic [7:0] cutoff_q;
  logic [5:0] intype_q;
  logic [3:0] opctrl_q;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic [7:0] rx_byte;
  logic byte_done;

  // Valid subaddress test, used by ack and phase transition
  function automatic logic sub_valid(input logic [7:0] s);
    sub_valid = (s == filter_ctrl_pkg::SUB_CUTOFF) || (s == filter_ctrl_pkg::SUB_INTYPE) ||
                (s == filter_ctrl_pkg::SUB_OPCTRL);
  endfunction

  // Own slave address from the strap code
  function automatic logic [6:0] own_addr(input logic [1:0] a);
    if (a == filter_ctrl_pkg::ADS_HIGH) begin
      own_addr = filter_ctrl_pkg::SLAVE_ADS_HI;
    end else if (a == filter_ctrl_pkg::ADS_OPEN) begin
      own_addr = filter_ctrl_pkg::SLAVE_ADS_OPEN;
    end else begin
      own_addr = filter_ctrl_pkg::SLAVE_BASE;
    end
  endfunction

  serial_edge u_edge (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .scl(scl),
    .sda(sda_in),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det)
  );

  // Byte completes on the eighth rising clock edge
  assign rx_byte = {shift_q[6:0], sda_in};
  assign byte_done = scl_rise && (bit_q == filter_ctrl_pkg::BIT_LAST);

  // Strap is caught once, clocked, after reset release
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ads_q <= filter_ctrl_pkg::ADS_LOW;
      ads_taken_q <= 1'b0;
    end else if (ce && !ads_taken_q) begin
      ads_q <= ads_code;
      ads_taken_q <= 1'b1;
    end
  end

  // Bit counter and shifter; start always resynchronises
  always_ff @(posedge clk) begin
    if (!rstn) begin
      bit_q <= 4'h0;
      shift_q <= 8'h00;
    end else if (start_det || stop_det) begin
      bit_q <= 4'h0;
    end else if (scl_rise && bit_q <= filter_ctrl_pkg::BIT_LAST) begin
      shift_q <= rx_byte;
      bit_q <= bit_q + 4'h1;
    end else if (scl_rise && bit_q == filter_ctrl_pkg::BIT_ACK) begin
      // Ack clock high; not a data bit, so nothing is shifted
      bit_q <= bit_q + 4'h1;
    end else if (scl_fall && bit_q > filter_ctrl_pkg::BIT_ACK) begin
      bit_q <= 4'h0; // Ack clock over, next byte starts
    end
  end

  // Transfer phase; a write-only device rejects read bit too
  always_ff @(posedge clk) begin
    if (!rstn) begin
      phase_q <= ST_IDLE;
      sub_q <= 8'h00;
    end else if (start_det) begin
      phase_q <= ST_ADDR;
    end else if (stop_det) begin
      phase_q <= ST_IDLE;
    end else if (byte_done) begin
      case (phase_q)
        ST_ADDR: begin
          // Address plus write bit must match
          if (rx_byte == {own_addr(ads_q), 1'b0}) begin
            phase_q <= ST_SUB;
          end else begin
            phase_q <= ST_DONE;
          end
        end
        ST_SUB: begin
          sub_q <= rx_byte;
          phase_q <= sub_valid(rx_byte) ? ST_DATA : ST_NOREG;
        end
        ST_DATA: begin
          phase_q <= ST_DONE; // No auto-increment
        end
        ST_NOREG: begin
          phase_q <= ST_DONE; // Data byte taken but stored nowhere
        end
        default: begin
          phase_q <= phase_q;
        end
      endcase
    end
  end

  // Ack pulls data low from the falling edge after a good byte to the next
  // The decision is taken with the byte, so it never sees the updated phase
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ack_q <= 1'b0;
      ack_due_q <= 1'b0;
    end else if (start_det || stop_det) begin
      ack_q <= 1'b0;
      ack_due_q <= 1'b0;
    end else if (byte_done) begin
      // Data byte acked whenever the address matched, address and subaddress only when valid
      ack_due_q <= (phase_q == ST_ADDR && rx_byte == {own_addr(ads_q), 1'b0}) ||
                   (phase_q == ST_SUB && sub_valid(rx_byte)) ||
                   (phase_q == ST_DATA) || (phase_q == ST_NOREG);
    end else if (scl_fall && bit_q == filter_ctrl_pkg::BIT_ACK) begin
      ack_q <= ack_due_q;
    end else if (scl_fall && ack_q) begin
      ack_q <= 1'b0;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = ack_q;

  // Register writes on the data byte; reset loads defaults
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cutoff_q <= filter_ctrl_pkg::CUTOFF_RST;
      intype_q <= filter_ctrl_pkg::INTYPE_RST;
      opctrl_q <= filter_ctrl_pkg::OPCTRL_RST;
    end else if (byte_done && phase_q == ST_DATA) begin
      if (sub_q == filter_ctrl_pkg::SUB_CUTOFF) begin
        cutoff_q <= rx_byte; // Whole byte is the code
      end else if (sub_q == filter_ctrl_pkg::SUB_INTYPE) begin
        // Low two data bits dropped
        intype_q <= rx_byte[filter_ctrl_pkg::INTYPE_MSB:filter_ctrl_pkg::INTYPE_LSB];
      end else if (sub_q == filter_ctrl_pkg::SUB_OPCTRL) begin
        // Only the upper nibble is kept
        opctrl_q <= rx_byte[filter_ctrl_pkg::PD_BIT:filter_ctrl_pkg::SKIP_BIT];
      end
    end
  end

  // Analog controls; cutoff split into range and tuning
  assign cutoff_code_value = cutoff_q;
  assign tuning_range_select = cutoff_q[filter_ctrl_pkg::RANGE_BIT];
  assign tuning_value = cutoff_q[filter_ctrl_pkg::TUNE_MSB:0];
  // Input stage codes forwarded as written
  assign ch1_input_kind = intype_q[5:4];
  assign ch2_input_kind = intype_q[3:2];
  assign ch3_input_kind = intype_q[1:0];
  // Operating flags, nibble index = data bit minus 4
  assign power_down_flag = opctrl_q[3];
  // Pin overrides the flag and needs no bus write
  assign use_input_b = pair_select_pin | opctrl_q[2];
  assign ch1_half_cutoff = 1'b0; // Channel one never halves
  assign ch23_half_cutoff = opctrl_q[1] & ~opctrl_q[0];
  assign filter_bypass = opctrl_q[0];
  assign filter_enable = ~opctrl_q[0];

  // Pin high always gives input B
  pin_forces_b_a: assert property (@(posedge clk) disable iff (!rstn)
    pair_select_pin |-> use_input_b)
    else $error("select pin did not force input b");
  // Bypass hides half cutoff
  skip_hides_half_a: assert property (@(posedge clk) disable iff (!rstn)
    filter_bypass |-> !ch23_half_cutoff && !filter_enable)
    else $error("bypass left half cutoff or filter on");
  // Data byte write lands next cycle
  data_write_a: assert property (@(posedge clk) disable iff (!rstn)
    (byte_done && phase_q == ST_DATA && sub_q == filter_ctrl_pkg::SUB_CUTOFF) |=>
    cutoff_code_value == $past(rx_byte))
    else $error("cutoff write lost");
  // Reset defaults
  reset_defaults_a: assert property (@(posedge clk)
    !rstn |=> (cutoff_code_value == 8'h00 && !power_down_flag && !filter_bypass))
    else $error("defaults not loaded");
  // Unknown subaddress never reaches data phase
  bad_sub_a: assert property (@(posedge clk) disable iff (!rstn)
    (byte_done && phase_q == ST_SUB && !sub_valid(rx_byte)) |=> phase_q == ST_NOREG)
    else $error("invalid subaddress accepted");
  // Channel one never halves
  ch1_full_a: assert property (@(posedge clk) disable iff (!rstn)
    !ch1_half_cutoff)
    else $error("channel one halved");
  // Cutoff fields recombine to code
  cutoff_split_a: assert property (@(posedge clk) disable iff (!rstn)
    {tuning_range_select, tuning_value} == cutoff_code_value)
    else $error("cutoff fields mismatch");
  // Pair flag alone when pin low
  pair_flag_a: assert property (@(posedge clk) disable iff (!rstn)
    !pair_select_pin |-> use_input_b == opctrl_q[2])
    else $error("pair flag not honoured");
  // Data byte after an accepted address always earns an ack
  data_ack_a: assert property (@(posedge clk) disable iff (!rstn)
    (byte_done && (phase_q == ST_DATA || phase_q == ST_NOREG)) |=> ack_due_q)
    else $error("data byte not acked");
endmodule

// ==== tb/serial_host.sv ====
/*
  Behavioural two-wire bus host that writes the register bank.
  Assumes the bench resolves the open-drain data line and returns it as sda_line.
*/
module serial_host (
  // Clock
  input wire logic clk,
  // Resolved data line
  input wire logic sda_line,
  // Driven lines, data released means high
  output logic scl,
  output logic sda_drv
);
  timeunit 1ns;
  timeprecision 100ps;
  // Half bit in clk cycles, kept above the four the port needs
  localparam int HALF = 6;
  // Bus idle: both lines released high
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Pass n edges, then step off the edge so changes never race it
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One byte MSB first, ninth clock samples the answer while scl is high
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_drv = b[i];
      tick(HALF);
      scl = 1'b1;
      tick(HALF);
      scl = 1'b0;
    end
    sda_drv = 1'b1; // Released so the device may pull low
    tick(HALF);
    scl = 1'b1;
    tick(2);
    ack = ~sda_line;
    tick(HALF - 2);
    scl = 1'b0;
  endtask
  // Start, three bytes, stop; the host sends every byte, read bit included, and never reads
  task automatic write3(input logic [7:0] adr, input logic [7:0] sub, input logic [7:0] dat,
                        output logic [2:0] acks);
    sda_drv = 1'b0; // Start: data falls while clock high
    tick(HALF);
    scl = 1'b0;
    put_byte(adr, acks[2]);
    put_byte(sub, acks[1]);
    put_byte(dat, acks[0]);
    sda_drv = 1'b0;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_drv = 1'b1; // Stop: data rises while clock high
    tick(HALF);
  endtask
endmodule

// ==== tb/filter_control_register_bank_test.sv ====
/*
  Self-checking bench for the filter control register bank.
  Assumes the host model in serial_host.sv; ce is held high throughout.
*/
module filter_control_register_bank_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rstn, ce, scl, sda_drv, sda_in, sda_out, sda_oe, pin;
  logic [1:0] ads_code;
  logic [7:0] cutoff;
  logic [6:0] tune;
  logic [1:0] k1, k2, k3;
  logic rsel, pd, use_b, h1, h23, byp, fen;
  logic [2:0] acks;
  int num_errors = 0;
  int check_count = 0;
  // Pulled-up data line: low when either party pulls it
  assign sda_in = sda_drv & ~(sda_oe & ~sda_out);
  filter_control_register_bank dut (.clk(clk), .rstn(rstn), .ce(ce), .ads_code(ads_code), .scl(scl),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .pair_select_pin(pin), .cutoff_code_value(cutoff),
    .tuning_range_select(rsel), .tuning_value(tune), .ch1_input_kind(k1), .ch2_input_kind(k2),
    .ch3_input_kind(k3), .power_down_flag(pd), .use_input_b(use_b), .ch1_half_cutoff(h1),
    .ch23_half_cutoff(h23), .filter_bypass(byp), .filter_enable(fen));
  serial_host host (.clk(clk), .sda_line(sda_in), .scl(scl), .sda_drv(sda_drv));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Compare one value, count it, report a mismatch at once
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Print counts and verdict, then stop
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Hold reset 20 cycles with a given strap, then wait two edges before traffic
  task automatic do_reset(input logic [1:0] strap);
    rstn = 1'b0;
    ads_code = strap;
    repeat (20) @(posedge clk);
    #1;
    rstn = 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // One write cycle with its expected acknowledge pattern
  task automatic wr(input logic [7:0] adr, input logic [7:0] sub, input logic [7:0] dat, input logic [2:0] ea);
    host.write3(adr, sub, dat, acks);
    check("acks", {5'h00, ea}, {5'h00, acks});
  endtask
  // Operating outputs packed, expectation built from data byte and pin
  task automatic check_op(input logic [7:0] d);
    check("op", {2'h0, d[7], pin | d[6], 1'b0, d[5] & ~d[4], d[4], ~d[4]}, {2'h0, pd, use_b, h1, h23, byp, fen});
  endtask
  // Every flag at its default after reset
  task automatic test_defaults();
    check("cutoff", 8'h00, cutoff);
    check("kinds", 8'h00, {2'h0, k1, k2, k3});
    check_op(8'h00);
    $display("test defaults done");
  endtask
  // Range boundary codes and split into range flag and tuning value
  task automatic test_cutoff();
    logic [7:0] codes [5] = '{8'h7f, 8'h80, 8'hff, 8'h01, 8'h00};
    foreach (codes[i]) begin
      wr(8'h90, 8'h01, codes[i], 3'h7);
      check("cutoff", codes[i], cutoff);
      check("range_tune", codes[i], {rsel, tune});
    end
    $display("test cutoff done");
  endtask
  // Channel fields forwarded unchanged, low data bits dropped
  task automatic test_intype();
    wr(8'h90, 8'h02, 8'he7, 3'h7);
    check("kinds", 8'h39, {2'h0, k1, k2, k3});
    wr(8'h90, 8'h02, 8'h1b, 3'h7);
    check("kinds", 8'h06, {2'h0, k1, k2, k3});
    check("cutoff", 8'h00, cutoff);
    $display("test intype done");
  endtask
  // Each operating flag, with the select pin low and high
  task automatic test_opctrl();
    logic [7:0] vals [5] = '{8'hff, 8'h2f, 8'h40, 8'h10, 8'h00};
    foreach (vals[i]) begin
      wr(8'h90, 8'h03, vals[i], 3'h7);
      check_op(vals[i]);
      pin = 1'b1;
      @(posedge clk);
      #1;
      check_op(vals[i]);
      pin = 1'b0;
    end
    $display("test opctrl done");
  endtask
  // Foreign address, read bit and bad subaddresses change nothing
  task automatic test_refuse();
    wr(8'h90, 8'h01, 8'h55, 3'h7);
    wr(8'h92, 8'h01, 8'haa, 3'h0);
    wr(8'h91, 8'h01, 8'haa, 3'h0);
    wr(8'h90, 8'h04, 8'haa, 3'h5);
    wr(8'h90, 8'h00, 8'haa, 3'h5);
    check("cutoff", 8'h55, cutoff);
    $display("test refuse done");
  endtask
  // Other strap settings move the address; reset reloads defaults
  task automatic test_strap();
    logic [7:0] adrs [2] = '{8'h92, 8'h94};
    foreach (adrs[i]) begin
      do_reset(2'(i + 1));
      check("cutoff", 8'h00, cutoff);
      wr(8'h90, 8'h01, 8'h33, 3'h0);
      wr(adrs[i], 8'h01, 8'h44, 3'h7);
      check("cutoff", 8'h44, cutoff);
    end
    $display("test strap done");
  endtask
  // Watchdog well above the roughly 7400 cycles the tests take
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    $display("FAIL watchdog expected done seen hang");
    end_of_test();
  end
  // Main sequence
  initial begin
    ce = 1'b1;
    pin = 1'b0;
    do_reset(2'h0);
    test_defaults();
    test_cutoff();
    test_intype();
    test_opctrl();
    test_refuse();
    test_strap();
    end_of_test();
  end
endmodule
